/* File: rtl/dcc_channel_control.sv */
`timescale 1ns/1ps
`include "dcc_consts.svh"
// Operation
// - Gain code 0xFF is 0dB, -0.5dB per step
// - Code one is -127dB, zero mutes
// - Left1/right1 attenuation read/write, reset 0xFF
// - Phase-invert bits flip matching output polarity
// - Swap clear: pair2 left-left, right-right
// - Swap set: pair2 left/right outputs exchanged
// - Speed code 000/001/010 normal/double/quad
// - Super-gentle roll-off enable bit, default off
// - Per-channel enables gate zero detection to pin
// - Zero-flag enable A resets to 0x01
// - Phase/swap/speed register resets to 0x00
// - Zero-flag enable B resets to 0x00
// - Polarity bit selects zero-flag active level
// - Power-down pin low restores register and gain defaults; audio outputs keep updating
// - Gain changes ramp over selected sample periods
// - Speed low bits come from pins speed_code_mid and speed_code_low
module dcc_channel_control (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 power_down_pin,
    input  wire logic                 ctrlCsN,
    input  wire logic                 ctrlClk,
    input  wire logic                 ctrlDataIn,
    output logic                      ctrlDataOut,
    output logic                      ctrlDataOutEnN,
    input  wire logic                 speed_code_mid,
    input  wire logic                 speed_code_low,
    input  wire logic                 zero_flag_polarity,
    input  wire logic [1:0]           gain_ramp_time,
    input  wire logic                 sampleTick,
    input  wire dcc_pkg::dcc_pair_type pair1In,
    input  wire dcc_pkg::dcc_pair_type pair2In,
    input  wire logic [7:0]           zeroDetect,
    output dcc_pkg::dcc_pair_type     pair1Out,
    output dcc_pkg::dcc_pair_type     pair2Out,
    output dcc_pkg::dcc_gain_type     gainPair1,
    output dcc_pkg::dcc_speed_type    speedMode,
    output logic                      super_gentle_rolloff_en,
    output logic                      zero_flag_pin
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] csSync_r;
    logic [1:0] sclkSync_r;
    logic [1:0] sdiSync_r;
    logic [1:0] pdnSync_r;
    logic [1:0] spdSync_r;
    logic [1:0] spdLowSync_r;
    logic [1:0] polSync_r;
    logic       sclkPrev_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            csSync_r     <= 2'h3;
            sclkSync_r   <= 2'h0;
            sdiSync_r    <= 2'h0;
            pdnSync_r    <= 2'h3;
            spdSync_r    <= 2'h0;
            spdLowSync_r <= 2'h0;
            polSync_r    <= 2'h0;
            sclkPrev_r   <= 1'b0;
        end else begin
            csSync_r     <= {csSync_r[0], ctrlCsN};
            sclkSync_r   <= {sclkSync_r[0], ctrlClk};
            sdiSync_r    <= {sdiSync_r[0], ctrlDataIn};
            pdnSync_r    <= {pdnSync_r[0], power_down_pin};
            spdSync_r    <= {spdSync_r[0], speed_code_mid};
            spdLowSync_r <= {spdLowSync_r[0], speed_code_low};
            polSync_r    <= {polSync_r[0], zero_flag_polarity};
            sclkPrev_r   <= sclkSync_r[1];
        end
    end

    logic csActive;
    logic sclkRise;
    logic sclkFall;
    logic powerDown;

    assign csActive  = !csSync_r[1];
    assign sclkRise  = csActive && sclkSync_r[1] && !sclkPrev_r;
    assign sclkFall  = csActive && !sclkSync_r[1] && sclkPrev_r;
    assign powerDown = !pdnSync_r[1];

    // ==========================================================
    // Serial control slave: R/W, 7-bit address, 8 data bits, MSB first
    // ==========================================================
    logic [14:0] shift_r;
    logic [4:0]  bitCount_r;
    logic [7:0]  readShift_r;
    logic        isRead_r;
    logic        writeStrobe;
    logic [6:0]  frameAddr;
    logic [7:0]  readData;
    logic [6:0]  readAddr;

    // On the eighth rising edge the address is still the low bits plus the incoming bit
    assign readAddr    = {shift_r[5:0], sdiSync_r[1]};
    assign frameAddr   = shift_r[13:7];
    assign writeStrobe = sclkRise && (bitCount_r == 5'(`DCC_FRAME_BITS - 1)) && shift_r[14];

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_r    <= 15'h0000;
            bitCount_r <= 5'h00;
        end else if (!csActive) begin
            bitCount_r <= 5'h00;
        end else if (sclkRise) begin
            shift_r <= {shift_r[13:0], sdiSync_r[1]};
            if (bitCount_r != 5'(`DCC_FRAME_BITS))
                bitCount_r <= bitCount_r + 5'h01;
        end
    end

    // Read data is loaded once the address is complete and shifted out on falling edges,
    // so the host samples each bit on the following rising edge.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            readShift_r <= 8'h00;
            isRead_r    <= 1'b0;
        end else if (!csActive) begin
            isRead_r <= 1'b0;
        end else if (sclkRise && bitCount_r == 5'(`DCC_FRAME_BITS - `DCC_DATA_BITS - 1)) begin
            isRead_r    <= !shift_r[6];
            readShift_r <= readData;
        end else if (sclkFall && isRead_r && bitCount_r > 5'(`DCC_FRAME_BITS - `DCC_DATA_BITS)) begin
            readShift_r <= {readShift_r[6:0], 1'b0};
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrlDataOut    <= 1'b0;
            ctrlDataOutEnN <= 1'b1;
        end else begin
            ctrlDataOut    <= readShift_r[7];
            ctrlDataOutEnN <= !(isRead_r && csActive);
        end
    end

    // ==========================================================
    // Register bank
    // ==========================================================
    logic [7:0] left1Att_r;
    logic [7:0] right1Att_r;
    logic [7:0] phaseCtrl_r;
    logic [7:0] zfEnA_r;
    logic [7:0] zfEnB_r;

    // Reserved bits are stored like any other bit and read back as written
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            left1Att_r  <= `DCC_RST_ATT;
            right1Att_r <= `DCC_RST_ATT;
            phaseCtrl_r <= `DCC_RST_PHASE_CTRL;
            zfEnA_r     <= `DCC_RST_ZF_EN_A;
            zfEnB_r     <= `DCC_RST_ZF_EN_B;
        end else if (powerDown) begin
            left1Att_r  <= `DCC_RST_ATT;
            right1Att_r <= `DCC_RST_ATT;
            phaseCtrl_r <= `DCC_RST_PHASE_CTRL;
            zfEnA_r     <= `DCC_RST_ZF_EN_A;
            zfEnB_r     <= `DCC_RST_ZF_EN_B;
        end else if (writeStrobe) begin
            unique case (frameAddr)
                `DCC_ADDR_LEFT1_ATT:  left1Att_r  <= {shift_r[6:0], sdiSync_r[1]};
                `DCC_ADDR_RIGHT1_ATT: right1Att_r <= {shift_r[6:0], sdiSync_r[1]};
                `DCC_ADDR_PHASE_CTRL: phaseCtrl_r <= {shift_r[6:0], sdiSync_r[1]};
                `DCC_ADDR_ZF_EN_A:    zfEnA_r     <= {shift_r[6:0], sdiSync_r[1]};
                `DCC_ADDR_ZF_EN_B:    zfEnB_r     <= {shift_r[6:0], sdiSync_r[1]};
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (readAddr)
            `DCC_ADDR_LEFT1_ATT:  readData = left1Att_r;
            `DCC_ADDR_RIGHT1_ATT: readData = right1Att_r;
            `DCC_ADDR_PHASE_CTRL: readData = phaseCtrl_r;
            `DCC_ADDR_ZF_EN_A:    readData = zfEnA_r;
            `DCC_ADDR_ZF_EN_B:    readData = zfEnB_r;
            default:              readData = 8'h00;
        endcase
    end

    // ==========================================================
    // Speed and filter decode
    // ==========================================================
    logic [2:0] speedCode;

    assign speedCode = {phaseCtrl_r[`DCC_BIT_SPEED_TOP], spdSync_r[1], spdLowSync_r[1]};

    // Undefined codes are flagged rather than aliased so the core can hold its last mode
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            speedMode <= dcc_pkg::SPEED_NORMAL;
        end else begin
            unique case (speedCode)
                3'h0:    speedMode <= dcc_pkg::SPEED_NORMAL;
                3'h1:    speedMode <= dcc_pkg::SPEED_DOUBLE;
                3'h2:    speedMode <= dcc_pkg::SPEED_QUAD;
                default: speedMode <= dcc_pkg::SPEED_UNDEFINED;
            endcase
        end
    end

    assign super_gentle_rolloff_en = phaseCtrl_r[`DCC_BIT_SUPER_GENTLE];

    // ==========================================================
    // Gain ramp, one code per step interval
    // ==========================================================
    logic [4:0] stepLen;
    logic [4:0] stepCount_r;
    logic       stepTick;
    logic [7:0] gainLeft_r;
    logic [7:0] gainRight_r;

    always_comb begin
        unique case (gain_ramp_time)
            2'h0: stepLen = 5'(`DCC_RAMP_TOTAL_0 / `DCC_RAMP_CODES);
            2'h1: stepLen = 5'(`DCC_RAMP_TOTAL_1 / `DCC_RAMP_CODES);
            2'h2: stepLen = 5'(`DCC_RAMP_TOTAL_2 / `DCC_RAMP_CODES);
            2'h3: stepLen = 5'(`DCC_RAMP_TOTAL_3 / `DCC_RAMP_CODES);
        endcase
    end

    assign stepTick = sampleTick && (stepCount_r + 5'h01 >= stepLen);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stepCount_r <= 5'h00;
        end else if (sampleTick) begin
            stepCount_r <= stepTick ? 5'h00 : stepCount_r + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gainLeft_r  <= `DCC_GAIN_FULL;
            gainRight_r <= `DCC_GAIN_FULL;
        end else if (powerDown) begin
            gainLeft_r  <= `DCC_GAIN_FULL;
            gainRight_r <= `DCC_GAIN_FULL;
        end else if (stepTick) begin
            if (gainLeft_r < left1Att_r)
                gainLeft_r <= gainLeft_r + 8'h01;
            else if (gainLeft_r > left1Att_r)
                gainLeft_r <= gainLeft_r - 8'h01;
            if (gainRight_r < right1Att_r)
                gainRight_r <= gainRight_r + 8'h01;
            else if (gainRight_r > right1Att_r)
                gainRight_r <= gainRight_r - 8'h01;
        end
    end

    // Code is dB*2 above -127.5dB; the multiplier downstream maps it, zero forces silence
    assign gainPair1.gainLeft  = gainLeft_r;
    assign gainPair1.gainRight = gainRight_r;
    assign gainPair1.muteLeft  = (gainLeft_r == `DCC_GAIN_MUTE);
    assign gainPair1.muteRight = (gainRight_r == `DCC_GAIN_MUTE);

    // ==========================================================
    // Output routing and polarity
    // ==========================================================
    logic [31:0] pair2Left;
    logic [31:0] pair2Right;

    assign pair2Left  = phaseCtrl_r[`DCC_BIT_PAIR2_SWAP] ? pair2In.right : pair2In.left;
    assign pair2Right = phaseCtrl_r[`DCC_BIT_PAIR2_SWAP] ? pair2In.left  : pair2In.right;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pair1Out <= '0;
            pair2Out <= '0;
        end else if (sampleTick) begin
            pair1Out.left  <= phaseCtrl_r[`DCC_BIT_INV_LEFT1]  ? 32'h0000_0000 - pair1In.left  : pair1In.left;
            pair1Out.right <= phaseCtrl_r[`DCC_BIT_INV_RIGHT1] ? 32'h0000_0000 - pair1In.right : pair1In.right;
            pair2Out.left  <= phaseCtrl_r[`DCC_BIT_INV_LEFT2]  ? 32'h0000_0000 - pair2Left     : pair2Left;
            pair2Out.right <= phaseCtrl_r[`DCC_BIT_INV_RIGHT2] ? 32'h0000_0000 - pair2Right    : pair2Right;
        end
    end

    // ==========================================================
    // Zero flag
    // ==========================================================
    // zeroDetect order: [0]L1 [1]R1 [2]L2 [3]R2 [4]L3 [5]R3 [6]L4 [7]R4, taken from input data
    logic [7:0] zfEnable;
    logic       zeroHit;

    assign zfEnable = {zfEnA_r[`DCC_BIT_ZFA_RIGHT4], zfEnB_r[`DCC_BIT_ZFB_LEFT4],
                       zfEnB_r[`DCC_BIT_ZFB_RIGHT3], zfEnA_r[`DCC_BIT_ZFA_LEFT3],
                       zfEnA_r[`DCC_BIT_ZFA_RIGHT2], zfEnB_r[`DCC_BIT_ZFB_LEFT2],
                       zfEnB_r[`DCC_BIT_ZFB_RIGHT1], zfEnA_r[`DCC_BIT_ZFA_LEFT1]};

    // All enabled channels must be silent; with none enabled the flag never fires
    assign zeroHit = (|zfEnable) && ((zeroDetect & zfEnable) == zfEnable);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            zero_flag_pin <= 1'b0;
        end else begin
            zero_flag_pin <= zeroHit ^ polSync_r[1];
        end
    end

endmodule

/* File: rtl/dcc_consts.svh */
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// Register offsets
`define DCC_ADDR_LEFT1_ATT     7'h03
`define DCC_ADDR_RIGHT1_ATT    7'h04
`define DCC_ADDR_PHASE_CTRL    7'h05
`define DCC_ADDR_ZF_EN_A       7'h07
`define DCC_ADDR_ZF_EN_B       7'h08

// Reset values
`define DCC_RST_ATT            8'hff
`define DCC_RST_PHASE_CTRL     8'h00
`define DCC_RST_ZF_EN_A        8'h01
`define DCC_RST_ZF_EN_B        8'h00

// Field positions in the phase / swap / speed register
`define DCC_BIT_INV_LEFT1      7
`define DCC_BIT_INV_RIGHT1     6
`define DCC_BIT_INV_LEFT2      5
`define DCC_BIT_INV_RIGHT2     4
`define DCC_BIT_PAIR2_SWAP     3
`define DCC_BIT_SPEED_TOP      1
`define DCC_BIT_SUPER_GENTLE   0

// Field positions in the zero-flag enable registers
`define DCC_BIT_ZFA_RIGHT2     7
`define DCC_BIT_ZFA_RIGHT4     6
`define DCC_BIT_ZFA_LEFT3      5
`define DCC_BIT_ZFA_LEFT1      4
`define DCC_BIT_ZFB_RIGHT1     7
`define DCC_BIT_ZFB_RIGHT3     6
`define DCC_BIT_ZFB_LEFT2      5
`define DCC_BIT_ZFB_LEFT4      4

// Gain codes
`define DCC_GAIN_FULL          8'hff
`define DCC_GAIN_MUTE          8'h00

// Ramp: samples per gain step for each ramp-time code (total / 255 codes)
`define DCC_RAMP_TOTAL_0       4080
`define DCC_RAMP_TOTAL_1       2040
`define DCC_RAMP_TOTAL_2       510
`define DCC_RAMP_TOTAL_3       255
`define DCC_RAMP_CODES         255

// Serial control frame
`define DCC_FRAME_BITS         16
`define DCC_DATA_BITS          8

`endif

/* File: rtl/dcc_pkg.sv */
package dcc_pkg;

    typedef enum logic [1:0] {
        SPEED_NORMAL,
        SPEED_DOUBLE,
        SPEED_QUAD,
        SPEED_UNDEFINED
    } dcc_speed_type;

    typedef struct packed {
        logic [31:0] left;
        logic [31:0] right;
    } dcc_pair_type;

    typedef struct packed {
        logic [7:0] gainLeft;
        logic [7:0] gainRight;
        logic       muteLeft;
        logic       muteRight;
    } dcc_gain_type;

endpackage

/* File: test/dcc_channel_control_assertions.sv */
`timescale 1ns/1ps
// ====================================
// Port-level checks of the control block
module dcc_channel_control_assertions (
    input wire logic                   clk,
    input wire logic                   resetn,
    input wire logic                   power_down_pin,
    input wire logic                   ctrlCsN,
    input wire logic                   ctrlDataOutEnN,
    input wire logic                   speed_code_mid,
    input wire logic                   speed_code_low,
    input wire logic                   zero_flag_polarity,
    input wire logic                   sampleTick,
    input wire logic [7:0]             zeroDetect,
    input wire dcc_pkg::dcc_pair_type  pair1Out,
    input wire dcc_pkg::dcc_pair_type  pair2Out,
    input wire dcc_pkg::dcc_gain_type  gainPair1,
    input wire dcc_pkg::dcc_speed_type speedMode,
    input wire logic                   super_gentle_rolloff_en,
    input wire logic                   zero_flag_pin
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Power-down jumps gain outputs to defaults, so settle checks wait out the pin sync
    logic [2:0] pdHighCnt_r;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pdHighCnt_r <= 3'h0;
        end else if (!power_down_pin) begin
            pdHighCnt_r <= 3'h0;
        end else if (pdHighCnt_r != 3'h7) begin
            pdHighCnt_r <= pdHighCnt_r + 3'h1;
        end
    end

    sequence s_deselected;
        ctrlCsN [*6];
    endsequence
    sequence s_quiet;
        (zeroDetect == 8'h00 && $stable(zero_flag_polarity)) [*6];
    endsequence
    sequence s_powered_down;
        (!power_down_pin) [*6];
    endsequence

    property p_reset_release;
        $rose(resetn) |-> gainPair1.gainLeft == 8'hff && gainPair1.gainRight == 8'hff && ctrlDataOutEnN;
    endproperty
    a_reset_release: assert property (p_reset_release) else $error("Gain not full after reset");
    property p_mute;
        gainPair1.muteLeft == (gainPair1.gainLeft == 8'h00) && gainPair1.muteRight == (gainPair1.gainRight == 8'h00);
    endproperty
    a_mute: assert property (p_mute) else $error("Mute flag disagrees with gain code");
    property p_ramp_step;
        (pdHighCnt_r == 3'h7 && $changed(gainPair1.gainLeft)) |->
            $past(sampleTick) && (gainPair1.gainLeft - $past(gainPair1.gainLeft)) inside {8'h01, 8'hff};
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("Gain moved other than one step");
    property p_pair_hold;
        (pdHighCnt_r == 3'h7 && !$past(sampleTick)) |-> $stable(pair1Out) && $stable(pair2Out);
    endproperty
    a_pair_hold: assert property (p_pair_hold) else $error("Audio output changed without sample");
    property p_zf_idle;
        s_quiet |-> zero_flag_pin == zero_flag_polarity;
    endproperty
    a_zf_idle: assert property (p_zf_idle) else $error("Zero flag active with no zero input");
    property p_speed_undef;
        (speed_code_mid && speed_code_low) [*6] |-> speedMode == dcc_pkg::SPEED_UNDEFINED;
    endproperty
    a_speed_undef: assert property (p_speed_undef) else $error("Undefined speed code decoded");
    property p_en_release;
        s_deselected |-> ctrlDataOutEnN;
    endproperty
    a_en_release: assert property (p_en_release) else $error("Read data driven while deselected");
    property p_pd_defaults;
        s_powered_down |-> gainPair1.gainLeft == 8'hff && gainPair1.gainRight == 8'hff && !super_gentle_rolloff_en;
    endproperty
    a_pd_defaults: assert property (p_pd_defaults) else $error("Defaults not held in power-down");
endmodule

bind dcc_channel_control dcc_channel_control_assertions i_chk (
    .clk(clk), .resetn(resetn), .power_down_pin(power_down_pin), .ctrlCsN(ctrlCsN),
    .ctrlDataOutEnN(ctrlDataOutEnN), .speed_code_mid(speed_code_mid), .speed_code_low(speed_code_low),
    .zero_flag_polarity(zero_flag_polarity), .sampleTick(sampleTick), .zeroDetect(zeroDetect),
    .pair1Out(pair1Out), .pair2Out(pair2Out), .gainPair1(gainPair1), .speedMode(speedMode),
    .super_gentle_rolloff_en(super_gentle_rolloff_en), .zero_flag_pin(zero_flag_pin)
);

/* File: test/dcc_host_model.sv */
`timescale 1ns/1ps
// ====================================
// Serial control host
module dcc_host_model (
    input  wire logic clk,
    output logic      ctrlCsN,
    output logic      ctrlClk,
    output logic      ctrlDataIn,
    input  wire logic ctrlDataOut,
    input  wire logic ctrlDataOutEnN
);
    // Each serial clock phase spans five system clocks, above the sync minimum
    localparam int PHASE = 5;
    initial begin
        ctrlCsN = 1'b1;
        ctrlClk = 1'b0;
        ctrlDataIn = 1'b0;
    end
    task automatic waitClk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata, output logic [7:0] rdata);
        logic [15:0] frame;
        frame = {wr, addr, wdata};
        rdata = 8'h00;
        ctrlCsN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            // Unused data slots of a read toggle so a stale level is never trusted
            ctrlDataIn = (wr || i > 7) ? frame[i] : ~ctrlDataIn;
            waitClk(PHASE);
            ctrlClk = 1'b1;
            if (!wr && i < 8) begin
                rdata[i] = ctrlDataOutEnN ? 1'bx : ctrlDataOut;
            end
            waitClk(PHASE);
            ctrlClk = 1'b0;
        end
        waitClk(PHASE);
        ctrlCsN = 1'b1;
        waitClk(PHASE);
    endtask
endmodule

/* File: test/tb_dcc_channel_control.sv */
`timescale 1ns/1ps
// ====================================
// Bench
module tb_dcc_channel_control;
    logic                   clk, resetn, power_down_pin, sampleTick;
    logic                   ctrlCsN, ctrlClk, ctrlDataIn, ctrlDataOut, ctrlDataOutEnN;
    logic                   speed_code_mid, speed_code_low, zero_flag_polarity;
    logic                   super_gentle_rolloff_en, zero_flag_pin;
    logic [1:0]             gain_ramp_time;
    logic [7:0]             zeroDetect, v;
    logic [31:0]            sl, sr;
    dcc_pkg::dcc_pair_type  pair1In, pair2In, pair1Out, pair2Out;
    dcc_pkg::dcc_gain_type  gainPair1;
    dcc_pkg::dcc_speed_type speedMode;
    int                     mismatches = 0;
    int                     checked = 0;
    logic [6:0]             addrTab [5] = '{7'h03, 7'h04, 7'h05, 7'h07, 7'h08};
    logic [7:0]             rstTab [5] = '{8'hff, 8'hff, 8'h00, 8'h01, 8'h00};
    logic [7:0]             maskTab [5] = '{8'hff, 8'hff, 8'hf9, 8'hf0, 8'hf0};
    logic [7:0]             cfgTab [4] = '{8'hf8, 8'h00, 8'ha9, 8'h51};

    dcc_channel_control i_dut (
        .clk(clk), .resetn(resetn), .power_down_pin(power_down_pin), .ctrlCsN(ctrlCsN), .ctrlClk(ctrlClk),
        .ctrlDataIn(ctrlDataIn), .ctrlDataOut(ctrlDataOut), .ctrlDataOutEnN(ctrlDataOutEnN),
        .speed_code_mid(speed_code_mid), .speed_code_low(speed_code_low), .zero_flag_polarity(zero_flag_polarity),
        .gain_ramp_time(gain_ramp_time), .sampleTick(sampleTick), .pair1In(pair1In), .pair2In(pair2In),
        .zeroDetect(zeroDetect), .pair1Out(pair1Out), .pair2Out(pair2Out), .gainPair1(gainPair1),
        .speedMode(speedMode), .super_gentle_rolloff_en(super_gentle_rolloff_en), .zero_flag_pin(zero_flag_pin)
    );
    dcc_host_model i_host (
        .clk(clk), .ctrlCsN(ctrlCsN), .ctrlClk(ctrlClk), .ctrlDataIn(ctrlDataIn),
        .ctrlDataOut(ctrlDataOut), .ctrlDataOutEnN(ctrlDataOutEnN)
    );

    // ====================================
    // Helpers
    function automatic logic [31:0] polar(input logic [31:0] s, input logic inv);
        return inv ? 32'h0000_0000 - s : s;
    endfunction
    function automatic logic zfExp(input logic [7:0] zd, input logic [7:0] m, input logic pol);
        return (((zd & m) == m) && (m != 8'h00)) ^ pol;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] expv);
        checked++;
        if (seen !== expv) begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] x;
        i_host.xfer(1'b1, a, d, x);
    endtask
    task automatic rdChk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] x;
        i_host.xfer(1'b0, a, 8'h00, x);
        check(x, e);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            sampleTick = 1'b1;
            cyc(1);
            sampleTick = 1'b0;
            cyc(1);
        end
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ====================================
    // Clock, watchdog and tests
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #200_000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h0f7a_965c));
        resetn = 1'b0;
        power_down_pin = 1'b1;
        sampleTick = 1'b0;
        speed_code_mid = 1'b0;
        speed_code_low = 1'b0;
        zero_flag_polarity = 1'b0;
        gain_ramp_time = 2'h3;
        zeroDetect = 8'h00;
        pair1In = '0;
        pair2In = '0;
        cyc(16);
        resetn = 1'b1;
        cyc(4);
        foreach (addrTab[i]) rdChk(addrTab[i], rstTab[i]);
        foreach (addrTab[i]) begin
            v = (8'($urandom()) & maskTab[i]) | (rstTab[i] & ~maskTab[i]);
            wr(addrTab[i], v);
            rdChk(addrTab[i], v);
        end
        wr(7'h06, 8'h5a);
        rdChk(7'h06, 8'h00);
        // Gain ramps one code per step toward the written value
        wr(7'h03, 8'hfc);
        wr(7'h04, 8'hfd);
        tick(3);
        check(gainPair1.gainLeft, 8'hfc);
        check(gainPair1.gainRight, 8'hfd);
        wr(7'h03, 8'h00);
        tick(251);
        check({gainPair1.gainLeft, gainPair1.muteLeft}, {8'h01, 1'b0});
        tick(1);
        check({gainPair1.gainLeft, gainPair1.muteLeft}, {8'h00, 1'b1});
        gain_ramp_time = 2'h0;
        wr(7'h03, 8'h03);
        tick(32);
        check(gainPair1.gainLeft, 8'h02);
        gain_ramp_time = 2'h2;
        tick(1);
        check(gainPair1.gainLeft, 8'h02);
        tick(1);
        check(gainPair1.gainLeft, 8'h03);
        gain_ramp_time = 2'h1;
        wr(7'h03, 8'h05);
        tick(15);
        check(gainPair1.gainLeft, 8'h04);
        tick(1);
        check(gainPair1.gainLeft, 8'h05);
        foreach (cfgTab[k]) begin
            wr(7'h05, cfgTab[k]);
            pair1In = {$urandom(), $urandom()};
            pair2In = {$urandom(), $urandom()};
            tick(1);
            check(super_gentle_rolloff_en, cfgTab[k][0]);
            check(pair1Out, {polar(pair1In.left, cfgTab[k][7]), polar(pair1In.right, cfgTab[k][6])});
            sl = cfgTab[k][3] ? pair2In.right : pair2In.left;
            sr = cfgTab[k][3] ? pair2In.left : pair2In.right;
            check(pair2Out, {polar(sl, cfgTab[k][5]), polar(sr, cfgTab[k][4])});
        end
        for (int c = 0; c < 4; c++) begin
            speed_code_mid = c[1];
            speed_code_low = c[0];
            cyc(8);
            check(speedMode, c[1:0]);
        end
        speed_code_mid = 1'b0;
        speed_code_low = 1'b0;
        // Only left1 and right1 steer the flag; right1 output stays inverted
        wr(7'h07, 8'h11);
        wr(7'h08, 8'h80);
        for (int n = 0; n < 12; n++) begin
            zeroDetect = n[0] ? 8'h03 : 8'($urandom());
            zero_flag_polarity = n[1];
            cyc(6);
            check(zero_flag_pin, zfExp(zeroDetect, 8'h03, zero_flag_polarity));
        end
        zeroDetect = 8'h00;
        power_down_pin = 1'b0;
        cyc(8);
        check({gainPair1, super_gentle_rolloff_en}, {8'hff, 8'hff, 2'h0, 1'b0});
        power_down_pin = 1'b1;
        cyc(4);
        foreach (addrTab[i]) rdChk(addrTab[i], rstTab[i]);
        report_and_stop();
    end
endmodule
